/* File: include/drv_ctrl_map.vh */
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 20 MHz core clock
// Notes: Definitions only
`ifndef DRV_CTRL_MAP_VH
`define DRV_CTRL_MAP_VH
`define CTRL2_ADDR 8'h1b
`define CTRL2_RESET 16'h0006
`define PWM_ADDR 8'h40
`define PWM_RESET 16'h0000
`define BIT_PREDRIVER_ENABLE 15
`define BIT_AMPLIFIER_ENABLE 11
`define BIT_AUTOZERO_DISABLE 10
`define BIT_PUMP_SOFTSTART_DISABLE 9
`define BIT_PUMP_LDO_MODE 8
`define BIT_FAULT_CLEAR 0
`define BIT_ALL_CHANNEL_SHUTDOWN 0
`define BIT_UV_RESPONSE 1
`define CTRL2_WMASK 16'h8fce
`define CLK_MHZ 20
`define PWM_CYCLE_US 50
`define PWM_CYCLE_CNT (`PWM_CYCLE_US * `CLK_MHZ)
// Reload value of the period counter, one less than the cycle count
`define PWM_CYCLE_LAST 16'd999
`endif

/* File: verilog/pwm_period_tick.v */
// Purpose: One-cycle tick marking the end of each PWM period
// Assumes: Single core clock
// Notes: Drive current updates wait for this tick while the predriver is enabled
`default_nettype none
`include "drv_ctrl_map.vh"
module pwm_period_tick (
  input wire clk_i,
  input wire rst_n_i,
  output wire tick_o
);
  reg [15:0] count;
  assign tick_o = (count == 16'h0000);
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= 16'h0000;
    end else if (tick_o) begin
      count <= `PWM_CYCLE_LAST;
    end else begin
      count <= count - 16'h0001;
    end
  end
endmodule // pwm_period_tick
`default_nettype wire

/* File: verilog/gate_output_stage.v */
// Purpose: Maps six PWM inputs onto the six gate outputs
// Assumes: Enable already qualified by fault logic
// Notes: Outputs registered; disabled means active pull-down
`default_nettype none
module gate_output_stage (
  input wire clk_i,
  input wire rst_n_i,
  input wire enable_i,
  input wire [2:0] high_side_pwm_input_i,
  input wire [2:0] low_side_pwm_input_i,
  output reg [2:0] gate_high_o,
  output reg [2:0] gate_low_o,
  output reg [5:0] pull_down_o
);
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : phase
      always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          gate_high_o[g] <= 1'b0;
          gate_low_o[g] <= 1'b0;
          pull_down_o[2*g] <= 1'b1;
          pull_down_o[2*g+1] <= 1'b1;
        end else begin
          gate_high_o[g] <= enable_i & high_side_pwm_input_i[g];
          gate_low_o[g] <= enable_i & low_side_pwm_input_i[g];
          pull_down_o[2*g] <= ~enable_i;
          pull_down_o[2*g+1] <= ~enable_i;
        end
      end
    end
  endgenerate
endmodule // gate_output_stage
`default_nettype wire

/* File: verilog/gate_driver_control_two.v */
// Purpose: Driver and amplifier control register with predriver gating
// Assumes: Synchronous inputs, 20 MHz core clock
// Notes: Fault detection lives outside; only its flags arrive here
`default_nettype none
`include "drv_ctrl_map.vh"
module gate_driver_control_two (
  input wire CORE_CLK_I,
  input wire RST_N_I,
  input wire [7:0] ADDR_I,
  input wire [15:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output reg [15:0] RDATA_O,
  input wire FAULT_LATCHED_I,
  input wire FAULT_ACTIVE_I,
  input wire FAULT_OUTPUT_LOW_I,
  input wire DRIVER_OFF_PIN_I,
  input wire GATE_SUPPLY_UNDERVOLTAGE_FLAG_I,
  input wire [2:0] HIGH_SIDE_PWM_INPUT_I,
  input wire [2:0] LOW_SIDE_PWM_INPUT_I,
  output wire [2:0] GATE_HIGH_O,
  output wire [2:0] GATE_LOW_O,
  output wire [5:0] GATE_PULL_DOWN_O,
  output wire PREDRIVER_ENABLE_O,
  output reg AMPLIFIER_ENABLE_O,
  output reg AMPLIFIER_OUTPUTS_HIZ_O,
  output reg AUTOZERO_RUN_O,
  output reg PUMP_SOFTSTART_ENABLE_O,
  output reg PUMP_LDO_FORCE_O,
  output reg PUMP_CLOCK_ENABLE_O,
  output reg FAULT_CLEAR_O,
  output reg [3:0] DRIVE_SOURCE_CURRENT_O,
  output reg [3:0] DRIVE_SINK_CURRENT_O
);
  reg [15:0] ctrl;
  reg [15:0] pwm_cfg;
  reg armed;
  reg [7:0] pend_current;
  wire tick;
  wire ctrl_wr = WR_I & (ADDR_I == `CTRL2_ADDR);
  wire pwm_wr = WR_I & (ADDR_I == `PWM_ADDR);
  wire all_channel_shutdown = pwm_cfg[`BIT_ALL_CHANNEL_SHUTDOWN];
  wire gate_supply_uv_response = pwm_cfg[`BIT_UV_RESPONSE];
  wire predriver_enable = ctrl[`BIT_PREDRIVER_ENABLE];
  // Conditions that force the enable low at the next clock edge
  wire force_off = (FAULT_LATCHED_I & all_channel_shutdown)
    | FAULT_ACTIVE_I | DRIVER_OFF_PIN_I;
  wire clr = ctrl_wr & WDATA_I[`BIT_FAULT_CLEAR];
  // Clear wins: enable refused when the same write clears a latched fault
  wire enable_ok = armed & ~(clr & FAULT_LATCHED_I);
  reg next_enable;

  always @* begin
    next_enable = predriver_enable;
    if (ctrl_wr) begin
      next_enable = WDATA_I[`BIT_PREDRIVER_ENABLE] & enable_ok;
    end
    if (force_off) begin
      next_enable = 1'b0;
    end
  end

  // Arm once fault output has been seen low (FAULT_OUTPUT_LOW_I) after power-up
  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      armed <= 1'b0;
    end else if (FAULT_OUTPUT_LOW_I) begin
      armed <= 1'b1;
    end
  end

  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl <= `CTRL2_RESET;
      FAULT_CLEAR_O <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        // Reserved and self-clearing bits never store
        ctrl <= (WDATA_I & `CTRL2_WMASK) | (ctrl & ~`CTRL2_WMASK);
      end
      ctrl[`BIT_PREDRIVER_ENABLE] <= next_enable;
      FAULT_CLEAR_O <= clr;
    end
  end

  // Drive currents and mode bits; current change deferred to period end while predriver enabled
  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pwm_cfg <= `PWM_RESET;
      pend_current <= 8'h00;
      DRIVE_SOURCE_CURRENT_O <= 4'h0;
      DRIVE_SINK_CURRENT_O <= 4'h0;
    end else begin
      if (pwm_wr) begin
        pwm_cfg <= WDATA_I;
        pend_current <= WDATA_I[15:8];
      end
      if (!predriver_enable || tick) begin
        DRIVE_SOURCE_CURRENT_O <= pwm_wr ? WDATA_I[15:12] : pend_current[7:4];
        DRIVE_SINK_CURRENT_O <= pwm_wr ? WDATA_I[11:8] : pend_current[3:0];
      end
    end
  end

  // Analog controls, registered from the control bits and, for the amplifier, the gate supply undervoltage flag
  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      AMPLIFIER_ENABLE_O <= 1'b0;
      AMPLIFIER_OUTPUTS_HIZ_O <= 1'b1;
      AUTOZERO_RUN_O <= 1'b1;
      PUMP_SOFTSTART_ENABLE_O <= 1'b1;
      PUMP_LDO_FORCE_O <= 1'b0;
      PUMP_CLOCK_ENABLE_O <= 1'b1;
    end else begin
      AMPLIFIER_ENABLE_O <= ctrl[`BIT_AMPLIFIER_ENABLE]
        & ~(gate_supply_uv_response & GATE_SUPPLY_UNDERVOLTAGE_FLAG_I);
      AMPLIFIER_OUTPUTS_HIZ_O <= ~ctrl[`BIT_AMPLIFIER_ENABLE]
        | (gate_supply_uv_response & GATE_SUPPLY_UNDERVOLTAGE_FLAG_I);
      AUTOZERO_RUN_O <= ~ctrl[`BIT_AUTOZERO_DISABLE];
      PUMP_SOFTSTART_ENABLE_O <= ~ctrl[`BIT_PUMP_SOFTSTART_DISABLE];
      PUMP_LDO_FORCE_O <= ctrl[`BIT_PUMP_LDO_MODE];
      PUMP_CLOCK_ENABLE_O <= ~ctrl[`BIT_PUMP_LDO_MODE];
    end
  end

  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RDATA_O <= 16'h0000;
    end else if (RD_I) begin
      case (ADDR_I)
        `CTRL2_ADDR: RDATA_O <= ctrl & `CTRL2_WMASK;
        `PWM_ADDR: RDATA_O <= pwm_cfg;
        default: RDATA_O <= 16'h0000;
      endcase
    end else begin
      RDATA_O <= 16'h0000;
    end
  end

  assign PREDRIVER_ENABLE_O = predriver_enable;

  pwm_period_tick u_tick (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .tick_o(tick)
  );

  gate_output_stage u_stage (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .enable_i(predriver_enable),
    .high_side_pwm_input_i(HIGH_SIDE_PWM_INPUT_I),
    .low_side_pwm_input_i(LOW_SIDE_PWM_INPUT_I),
    .gate_high_o(GATE_HIGH_O),
    .gate_low_o(GATE_LOW_O),
    .pull_down_o(GATE_PULL_DOWN_O)
  );
endmodule // gate_driver_control_two
`default_nettype wire

/* File: bench/gate_driver_control_two_props.sv */
// Purpose: Port checks for the control register block
// Assumes: One clock, async low reset
// Notes: Bound to every instance
`default_nettype none
module gdc2_props (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [15:0] RDATA_O,
  input wire logic FAULT_LATCHED_I,
  input wire logic FAULT_ACTIVE_I,
  input wire logic DRIVER_OFF_PIN_I,
  input wire logic [2:0] HIGH_SIDE_PWM_INPUT_I,
  input wire logic [2:0] GATE_HIGH_O,
  input wire logic [2:0] GATE_LOW_O,
  input wire logic [5:0] GATE_PULL_DOWN_O,
  input wire logic PREDRIVER_ENABLE_O,
  input wire logic AMPLIFIER_ENABLE_O,
  input wire logic FAULT_CLEAR_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  wire logic ctl_wr = WR_I && ADDR_I == 8'h1b;
  pin_off_a: assert property (DRIVER_OFF_PIN_I |=> !PREDRIVER_ENABLE_O)
    else $error("off pin ignored");
  fault_hold_a: assert property (FAULT_ACTIVE_I |=> !PREDRIVER_ENABLE_O)
    else $error("enable during fault");
  gates_idle_a: assert property (!PREDRIVER_ENABLE_O |=>
    GATE_HIGH_O == 3'h0 && GATE_LOW_O == 3'h0 && &GATE_PULL_DOWN_O) else $error("gates live");
  gates_follow_a: assert property (PREDRIVER_ENABLE_O |=>
    GATE_HIGH_O == $past(HIGH_SIDE_PWM_INPUT_I)) else $error("gates stuck");
  clear_pulse_a: assert property (ctl_wr && WDATA_I[0] |=> FAULT_CLEAR_O)
    else $error("no clear pulse");
  clear_wins_a: assert property (ctl_wr && WDATA_I[15] && WDATA_I[0] && FAULT_LATCHED_I
    && !PREDRIVER_ENABLE_O |=> !PREDRIVER_ENABLE_O) else $error("enable beat clear");
  read_idle_a: assert property (!RD_I |=> RDATA_O == 16'h0000)
    else $error("stray read data");
  amp_off_a: assert property (ctl_wr && !WDATA_I[11] |=> ##1 !AMPLIFIER_ENABLE_O)
    else $error("amplifier on");
endmodule // gdc2_props
bind gate_driver_control_two gdc2_props gdc2_props_i (.*);
`default_nettype wire

/* File: bench/host_model.sv */
// Purpose: Host side of the register port
// Assumes: Signals change just after the rising edge
// Notes: Tasks are called by the bench
`default_nettype none
module host_model (
  input wire logic clk,
  input wire logic [15:0] rdata,
  output logic [7:0] addr,
  output logic [15:0] wdata,
  output logic wr,
  output logic rd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end
  task automatic put(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic get(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Currents first; enable only after the fault pin settled
  task automatic start(input logic [15:0] cur);
    put(8'h40, cur);
    #5000;
    put(8'h1b, 16'h8200);
  endtask
endmodule // host_model
`default_nettype wire

/* File: bench/gate_driver_control_two_bench.sv */
// Purpose: Self-checking bench for the control register block
// Assumes: Host model owns the register port
// Notes: Random words plus fault and pin corner cases
`default_nettype none
module gate_driver_control_two_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ck = 1'b0, rn = 1'b0, fl = 1'b0, fa = 1'b0, fo = 1'b0, off = 1'b0, uv = 1'b0;
  logic [2:0] hi = 3'h0, lo = 3'h0, gh, gl;
  logic [7:0] a;
  logic [15:0] wd, rdat, d, v;
  logic w, r, en, amp, hz, az, ss, ldo, pc;
  logic [5:0] pd;
  logic [3:0] src, snk;
  int err_count = 0, n_compared = 0;
  always #25 ck = ~ck;
  host_model host_model_i (.clk(ck), .rdata(rdat), .addr(a), .wdata(wd), .wr(w), .rd(r));
  gate_driver_control_two gate_driver_control_two_i (
    .CORE_CLK_I(ck), .RST_N_I(rn), .ADDR_I(a), .WDATA_I(wd), .WR_I(w), .RD_I(r),
    .RDATA_O(rdat), .FAULT_LATCHED_I(fl), .FAULT_ACTIVE_I(fa), .FAULT_OUTPUT_LOW_I(fo),
    .DRIVER_OFF_PIN_I(off), .GATE_SUPPLY_UNDERVOLTAGE_FLAG_I(uv),
    .HIGH_SIDE_PWM_INPUT_I(hi), .LOW_SIDE_PWM_INPUT_I(lo), .GATE_HIGH_O(gh),
    .GATE_LOW_O(gl), .GATE_PULL_DOWN_O(pd), .PREDRIVER_ENABLE_O(en),
    .AMPLIFIER_ENABLE_O(amp), .AMPLIFIER_OUTPUTS_HIZ_O(hz), .AUTOZERO_RUN_O(az),
    .PUMP_SOFTSTART_ENABLE_O(ss), .PUMP_LDO_FORCE_O(ldo), .PUMP_CLOCK_ENABLE_O(pc),
    .FAULT_CLEAR_O(), .DRIVE_SOURCE_CURRENT_O(src), .DRIVE_SINK_CURRENT_O(snk));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Reserved and self-clearing bits never read back
  function automatic logic [15:0] ctl_exp(input logic [15:0] x);
    return x & 16'h8fce;
  endfunction
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    d = $urandom(32'h05257cf0);
    repeat (6) @(posedge ck);
    rn <= 1'b1;
    host_model_i.get(8'h1b, v);
    chk(v, 16'h0006);
    host_model_i.get(8'h77, v);
    chk(v, 16'h0000);
    host_model_i.put(8'h1b, 16'h8800);
    host_model_i.get(8'h1b, v);
    chk(v, 16'h0800);
    @(posedge ck);
    fo <= 1'b1;
    host_model_i.start(16'h5a03);
    host_model_i.get(8'h40, v);
    chk({en, src, snk}, 9'h15a);
    host_model_i.put(8'h40, 16'h3c03);
    repeat (1001) @(posedge ck);
    #1 chk({src, snk}, 8'h3c);
    repeat (12) begin
      d = $urandom;
      @(posedge ck);
      hi <= d[7:5];
      lo <= d[4:2];
      host_model_i.put(8'h1b, d);
      host_model_i.get(8'h1b, v);
      chk(v, ctl_exp(d));
      chk({amp, hz, az, ss, ldo, pc}, {d[11], ~d[11], ~d[10], ~d[9], d[8], ~d[8]});
      chk({gh, gl, pd}, {hi & {3{d[15]}}, lo & {3{d[15]}}, {6{~d[15]}}});
    end
    for (int k = 0; k < 2; k++) begin
      host_model_i.put(8'h1b, 16'h8000);
      {fa, off} <= k ? 2'b10 : 2'b01;
      host_model_i.put(8'h1b, 16'h8000);
      {fa, off} <= 2'b00;
      #1 chk(en, 1'b0);
    end
    host_model_i.put(8'h1b, 16'h8000);
    fl <= 1'b1;
    repeat (2) @(posedge ck);
    #1 chk(en, 1'b0);
    host_model_i.put(8'h1b, 16'h8001);
    fl <= 1'b0;
    #1 chk(en, 1'b0);
    host_model_i.put(8'h1b, 16'h0800);
    uv <= 1'b1;
    repeat (3) @(posedge ck);
    #1 chk(amp, 1'b0);
    close_out();
  end
endmodule // gate_driver_control_two_bench
`default_nettype wire
